// ### bench/cgqs_scheduler_tb.sv
// Self-checking bench of the channel group queue scheduler
`timescale 1ns/100ps

module cgqs_scheduler_tb;
	import cgqs_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic in_valid = 1'b0;
	logic in_ready;
	cgqs_dgram_t in_dgram = '0;
	logic out_valid;
	logic out_ready;
	cgqs_dgram_t out_dgram;
	logic hold = 1'b1; // Sink stalls while high
	int fails = 0;
	int checked = 0;
	int seed = 74;
	int seq = 0; // Payload sequence number
	int slot = 4; // Reference cyclic slot
	int lim = 13; // Reference round limit
	int n;
	logic took;
	cgqs_dgram_t e;
	cgqs_dgram_t exp_q[$]; // Expected output order
	logic [31:0] ref_q[16][$]; // Reference per-group contents

	cgqs_scheduler u_cgqs_scheduler (.clock(clock), .reset(reset),
		.in_valid(in_valid), .in_ready(in_ready), .in_dgram(in_dgram),
		.out_valid(out_valid), .out_ready(out_ready), .out_dgram(out_dgram));
	cgqs_sink u_cgqs_sink (.clock(clock), .reset(reset), .hold(hold),
		.out_valid(out_valid), .out_ready(out_ready));

	// Free running 250 MHz clock
	initial forever #2 clock = ~clock;

	task automatic check(input string what, input logic [35:0] seen,
		input logic [35:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Offer one datagram; valid stays up for a following offer
	task automatic push(input cgqs_grp_t grp, output logic ok);
		in_valid = 1'b1;
		in_dgram = {grp, 32'(seq)};
		// Ready is taken at the edge that would accept the datagram
		@(posedge clock) ok = in_ready;
		#1;
		if (ok)
		begin
			ref_q[grp].push_back(32'(seq));
			seq++;
		end
	endtask

	// Released bus shows the inverse, not a stale copy
	task automatic idle();
		in_valid = 1'b0;
		in_dgram = ~in_dgram;
	endtask

	// Cyclic order: rounds 4..13, 4..12, down to 4..4
	function automatic int pick();
		int s;
		for (int k = 0; k < 4; k++)
			if (ref_q[k].size() != 0)
				return k;
		for (int k = 4; k < 14; k++)
			if (ref_q[k].size() != 0)
				while (1)
				begin
					s = slot;
					slot++;
					if (slot > lim)
					begin
						slot = 4;
						lim = (lim == 4) ? 13 : lim - 1;
					end
					if (ref_q[s].size() != 0)
						return s;
				end
		for (int k = 14; k < 16; k++)
			if (ref_q[k].size() != 0)
				return k;
		return -1;
	endfunction

	task automatic predict();
		int k;
		k = pick();
		while (k >= 0)
		begin
			exp_q.push_back({4'(k), ref_q[k].pop_front()});
			k = pick();
		end
	endtask

	task automatic wait_drain(input int bound);
		for (n = 0; n < bound && exp_q.size() != 0; n++)
			@(posedge clock);
		if (exp_q.size() != 0)
		begin
			fails++;
			end_of_test();
		end
		#1;
	endtask

	// Park a marker in the output stage, load a batch, then drain
	task automatic batch(input int mode, input int cnt);
		cgqs_grp_t g;
		hold = 1'b1;
		push(4'hF, took);
		idle();
		predict();
		repeat (4) @(posedge clock);
		#1;
		for (int i = 0; i < cnt; i++)
		begin
			// source may tag any of the groups
			case (mode)
				0: g = 4'($random(seed) & 15);
				1: g = (i < 12) ? 4'h4 : (i < 14) ? 4'hD : 4'h9;
				default: g = 4'(15 - (i % 16));
			endcase
			push(g, took);
		end
		idle();
		predict();
		hold = 1'b0;
		wait_drain(3000);
	endtask

	// Each taken datagram against the oldest note
	always @(posedge clock)
		if (!reset && out_valid === 1'b1 && out_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("spare output", 36'h1, 36'h0);
			else
			begin
				e = exp_q.pop_front();
				check("group", 36'(out_dgram.group), 36'(e.group));
				check("data", 36'(out_dgram.data), 36'(e.data));
			end
		end

	initial
	begin
		repeat (4) @(posedge clock);
		#1 reset = 1'b0;
		check("out_valid after reset", 36'(out_valid), 36'h0);
		check("in_ready after reset", 36'(in_ready), 36'h1);
		batch(2, 32);
		batch(1, 17);
		batch(0, 60);
		// Fill group 14 behind a parked marker until refused
		hold = 1'b1;
		push(4'hE, took);
		idle();
		predict();
		repeat (4) @(posedge clock);
		#1;
		took = 1'b1;
		for (n = 0; n < 40 && took; n++)
			push(4'hE, took);
		idle();
		check("accepted until full", 36'(n), 36'h21);
		predict();
		hold = 1'b0;
		wait_drain(500);
		// Nothing may follow once every note is used up
		repeat (8) @(posedge clock);
		#1;
		check("idle after drain", 36'(out_valid), 36'h0);
		end_of_test();
	end
endmodule

// ### bench/cgqs_sink.sv
// Transmitter model that takes scheduled datagrams with random stalls
`timescale 1ns/100ps

module cgqs_sink
(
	input wire logic clock,
	input wire logic reset,
	input wire logic hold,
	input wire logic out_valid,
	output logic out_ready
);
	// Own random stream, so bench stimulus stays reproducible
	int seed = 74;

	// Ready changes just after the edge; three of four cycles take
	initial out_ready = 1'b0;
	always @(posedge clock)
		#1 out_ready = !reset && !hold && (($random(seed) & 3) != 0);
endmodule

// ### include/cgqs_defs.svh
// Constants of the channel group queue scheduler
`ifndef CGQS_DEFS_SVH
`define CGQS_DEFS_SVH

// Number of channel groups carried in the group tag
`define CGQS_NUM_GROUPS 16
// Width of the group tag field
`define CGQS_GRP_W 4
// Width of the payload word that travels with each datagram
`define CGQS_DATA_W 32
// Words held by each per-group queue
`define CGQS_FIFO_DEPTH 32

// Strictly ordered top band
`define CGQS_STRICT_FIRST 4'h0
`define CGQS_STRICT_LAST 4'h3
// Weighted cyclic band
`define CGQS_CYC_FIRST 4'h4
`define CGQS_CYC_LAST 4'hD
// Strictly ordered bottom band
`define CGQS_LOW_FIRST 4'hE
`define CGQS_LOW_LAST 4'hF

// Step of the cyclic slot pointer
`define CGQS_SLOT_STEP 4'h1

`endif

// ### include/cgqs_pkg.sv
// Types shared by the channel group queue scheduler
`include "cgqs_defs.svh"

package cgqs_pkg;

	// One queued datagram: its group tag and its payload word
	typedef struct packed {
		logic [`CGQS_GRP_W-1:0] group;
		logic [`CGQS_DATA_W-1:0] data;
	} cgqs_dgram_t;

	// Group index
	typedef logic [`CGQS_GRP_W-1:0] cgqs_grp_t;

	// One bit per channel group
	typedef logic [`CGQS_NUM_GROUPS-1:0] cgqs_mask_t;

endpackage

// ### src/cgqs_fifo.sv
// Parameterised first-in-first-out buffer with valid/ready on both sides
`timescale 1ns/100ps

module cgqs_fifo
#(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);

	// Pointer width; depth must be a power of two so pointers wrap freely
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

	// Storage array
	logic [WIDTH-1:0] mem_q [DEPTH];
	// Write and read pointers
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	// Words currently held
	logic [AW:0] level_q;
	// Accepted transfers on each side
	logic push;
	logic pop;

	// Honest full and empty straight from the level
	assign wr_ready = (level_q != FULL_LEVEL);
	assign rd_valid = (level_q != '0);
	assign rd_data = mem_q[rd_ptr_q];
	assign push = wr_valid && wr_ready;
	assign pop = rd_valid && rd_ready;

	// Storage write, no reset needed on data
	always_ff @(posedge clock)
	begin
		if (push)
		begin
			mem_q[wr_ptr_q] <= wr_data;
		end
	end

	// Pointer and level upkeep
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			level_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop)
			begin
				level_q <= level_q + 1'b1;
			end
			else if (pop && !push)
			begin
				level_q <= level_q - 1'b1;
			end
		end
	end

	chk_fifo_level_track: assert property (
		@(posedge clock) disable iff (reset)
		(push && !pop) |=> (level_q == $past(level_q) + 1'b1))
	else $error("fifo level did not grow on a lone push");

endmodule

// ### src/cgqs_scheduler.sv
// Prioritised transmit queue scheduler over sixteen channel groups
`timescale 1ns/100ps

// Constants must be visible even when this file is its own unit
`include "cgqs_defs.svh"

// Function
// - Four-bit group tag selects one of sixteen
// - Each group leaves in arrival order
// - Groups zero to three strictly by number
// - Cyclic band only when top band empty
// - Cyclic band served round robin, lower biased
// - Group four ten slots, thirteen one
// - Groups fourteen, fifteen last, fourteen first
module cgqs_scheduler
	import cgqs_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire cgqs_dgram_t in_dgram,
	output logic out_valid,
	input wire logic out_ready,
	output cgqs_dgram_t out_dgram
);

	// Occupancy and handshakes of the per-group queues
	cgqs_mask_t fifo_rd_valid;
	cgqs_mask_t fifo_wr_ready;
	cgqs_mask_t fifo_push;
	cgqs_mask_t fifo_pop;
	// Head datagram of every queue
	cgqs_dgram_t fifo_rd_data [`CGQS_NUM_GROUPS];

	// Cyclic slot pointer and the last group of the current round
	cgqs_grp_t slot_q;
	cgqs_grp_t lim_q;

	// Output holding stage
	logic out_valid_q;
	cgqs_dgram_t out_dgram_q;

	// Selection results
	logic take;
	logic sel_ok;
	cgqs_grp_t sel_idx;
	logic advance;
	logic pop;
	logic [`CGQS_GRP_W:0] strict_hit;
	logic [`CGQS_GRP_W:0] low_hit;
	logic cyc_any;

	// Lowest waiting group within a band; top bit says one was found
	function automatic logic [`CGQS_GRP_W:0] lowest_set(
		input cgqs_mask_t m,
		input cgqs_grp_t lo,
		input cgqs_grp_t hi);
		logic [`CGQS_GRP_W:0] r;
		r = '0;
		for (int i = 0; i < `CGQS_NUM_GROUPS; i++)
		begin
			// Only the first hit in the band counts
			if (!r[`CGQS_GRP_W] && m[i] &&
				(`CGQS_GRP_W'(i) >= lo) && (`CGQS_GRP_W'(i) <= hi))
			begin
				r = {1'b1, `CGQS_GRP_W'(i)};
			end
		end
		return r;
	endfunction

	// One queue per group keeps each group first-in-first-out
	generate
		for (genvar g = 0; g < `CGQS_NUM_GROUPS; g++)
		begin : g_queue
			assign fifo_push[g] = in_valid &&
				(in_dgram.group == `CGQS_GRP_W'(g));
			// Only the selected head is taken
			assign fifo_pop[g] = pop && (sel_idx == `CGQS_GRP_W'(g));

			cgqs_fifo #(
				.WIDTH($bits(cgqs_dgram_t)),
				.DEPTH(`CGQS_FIFO_DEPTH)
			) u_fifo (
				.clock(clock),
				.reset(reset),
				.wr_valid(fifo_push[g]),
				.wr_ready(fifo_wr_ready[g]),
				.wr_data(in_dgram),
				.rd_valid(fifo_rd_valid[g]),
				.rd_ready(fifo_pop[g]),
				.rd_data(fifo_rd_data[g])
			);
		end
	endgenerate

	// Back-pressure reaches the source only from the tagged group's queue
	assign in_ready = fifo_wr_ready[in_dgram.group];

	// The output stage can take a new datagram this cycle
	assign take = !out_valid_q || out_ready;

	// Picks the group to serve this cycle
	always_comb
	begin
		strict_hit = lowest_set(fifo_rd_valid, `CGQS_STRICT_FIRST,
			`CGQS_STRICT_LAST);
		low_hit = lowest_set(fifo_rd_valid, `CGQS_LOW_FIRST, `CGQS_LOW_LAST);
		cyc_any = |fifo_rd_valid[`CGQS_CYC_LAST:`CGQS_CYC_FIRST];
		sel_ok = 1'b0;
		sel_idx = '0;
		advance = 1'b0;
		if (strict_hit[`CGQS_GRP_W])
		begin
			sel_ok = 1'b1;
			sel_idx = strict_hit[`CGQS_GRP_W-1:0];
		end
		// cyclic band only when top band idle
		else if (cyc_any)
		begin
			// Slot is used up whether served or skipped
			advance = take;
			if (fifo_rd_valid[slot_q])
			begin
				sel_ok = 1'b1;
				sel_idx = slot_q;
			end
		end
		else if (low_hit[`CGQS_GRP_W])
		begin
			sel_ok = 1'b1;
			sel_idx = low_hit[`CGQS_GRP_W-1:0];
		end
	end

	assign pop = take && sel_ok;

	// Cyclic schedule: rounds of groups four up to a shrinking limit.
	// Skips cost one cycle each, a trade for avoiding a wide search.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			slot_q <= `CGQS_CYC_FIRST;
			lim_q <= `CGQS_CYC_LAST;
		end
		else if (advance)
		begin
			if (slot_q == lim_q)
			begin
				slot_q <= `CGQS_CYC_FIRST;
				// round limit shrinks, then cycle restarts
				if (lim_q == `CGQS_CYC_FIRST)
				begin
					lim_q <= `CGQS_CYC_LAST;
				end
				else
				begin
					lim_q <= lim_q - `CGQS_SLOT_STEP;
				end
			end
			else
			begin
				slot_q <= slot_q + `CGQS_SLOT_STEP;
			end
		end
	end

	// Output register; holds until the transmitter takes it
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			out_valid_q <= 1'b0;
			out_dgram_q <= '0;
		end
		else if (pop)
		begin
			out_valid_q <= 1'b1;
			out_dgram_q <= fifo_rd_data[sel_idx];
		end
		else if (out_ready)
		begin
			out_valid_q <= 1'b0;
		end
	end

	assign out_valid = out_valid_q;
	assign out_dgram = out_dgram_q;

	// push lands only in the tagged queue
	chk_push_one_hot: assert property (
		@(posedge clock) disable iff (reset)
		(in_valid && in_ready) |->
			(fifo_push == (cgqs_mask_t'(1) << in_dgram.group)))
	else $error("push did not target the tagged group");

	// emitted datagram carries the served group
	chk_out_group_match: assert property (
		@(posedge clock) disable iff (reset)
		pop |=> (out_valid && out_dgram.group == $past(sel_idx)))
	else $error("emitted group differs from the selected group");

	// no lower top group waiting when served
	chk_strict_top: assert property (
		@(posedge clock) disable iff (reset)
		(pop && sel_idx <= `CGQS_STRICT_LAST) |->
			((fifo_rd_valid & ((cgqs_mask_t'(1) << sel_idx) - 1'b1)) == '0))
	else $error("top band served out of strict order");

	// cyclic band waits for the top band
	chk_cyc_after_top: assert property (
		@(posedge clock) disable iff (reset)
		(pop && sel_idx >= `CGQS_CYC_FIRST && sel_idx <= `CGQS_CYC_LAST) |->
			(fifo_rd_valid[`CGQS_STRICT_LAST:`CGQS_STRICT_FIRST] == '0))
	else $error("cyclic band served while top band waited");

	// slot stays inside the current round
	chk_slot_bounds: assert property (
		@(posedge clock) disable iff (reset)
		(slot_q >= `CGQS_CYC_FIRST) && (slot_q <= lim_q) &&
			(lim_q <= `CGQS_CYC_LAST))
	else $error("cyclic slot left its round");

	// round end shrinks the limit by one
	chk_round_shrink: assert property (
		@(posedge clock) disable iff (reset)
		(advance && slot_q == lim_q && lim_q != `CGQS_CYC_FIRST) |=>
			(slot_q == `CGQS_CYC_FIRST) &&
			(lim_q == $past(lim_q) - `CGQS_SLOT_STEP))
	else $error("round limit did not step down");

	// bottom band only when all above empty
	chk_low_last: assert property (
		@(posedge clock) disable iff (reset)
		(pop && sel_idx >= `CGQS_LOW_FIRST) |->
			(fifo_rd_valid[`CGQS_CYC_LAST:`CGQS_STRICT_FIRST] == '0) &&
			(sel_idx == `CGQS_LOW_FIRST || !fifo_rd_valid[`CGQS_LOW_FIRST]))
	else $error("bottom band served too early or out of order");

	// skipped slot emits nothing and moves on
	chk_skip_empty: assert property (
		@(posedge clock) disable iff (reset)
		(advance && !fifo_rd_valid[slot_q]) |->
			!pop ##1 (slot_q != $past(slot_q) ||
			$past(slot_q) == `CGQS_CYC_FIRST))
	else $error("empty cyclic slot produced output or stalled");

endmodule
